/* File: tb.sv */
/*
 Self-checking bench for tcb_timers with the pin model on the far side.
 Assumes clk_sys is the oscillator; clk_en and interrupt 0 pin idle high.
*/
module tb;
	import tcb_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic [2:0] ack = 3'h0;
	logic [1:0] uart0_mode = 2'h0;
	logic [1:0] uart1_mode = 2'h0;
	logic clk_en = 1'b1;
	logic int0_pin = 1'b1;
	logic [4:0] pins;
	logic [7:0] sfr_rdata;
	logic [3:0] baud_tick;
	logic t0_overflow_flag, t1_overflow_flag, ext_int1_edge_flag, t2_overflow_flag, t2_ext_flag;
	logic [4:0] flg;
	int bad_count = 0;
	int total_checks = 0;
	assign flg = {t2_ext_flag, t2_overflow_flag, ext_int1_edge_flag, t1_overflow_flag, t0_overflow_flag};
	initial forever #5 clk_sys = ~clk_sys;
	tcb_pin_model u_pins (.clk_sys(clk_sys), .pins(pins));
	tcb_timers u_tcb_timers (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.count_pin_0(pins[0]), .count_pin_1(pins[1]), .count_pin_2(pins[2]), .t2_trigger_input(pins[3]),
		.ext_int0_pin(int0_pin), .ext_int1_pin(pins[4]), .t0_int_ack(ack[0]), .t1_int_ack(ack[1]),
		.ext1_int_ack(ack[2]), .uart0_mode(uart0_mode), .uart1_mode(uart1_mode),
		.t0_overflow_flag(t0_overflow_flag), .t1_overflow_flag(t1_overflow_flag),
		.ext_int1_edge_flag(ext_int1_edge_flag), .t2_overflow_flag(t2_overflow_flag),
		.t2_ext_flag(t2_ext_flag), .baud_tick(baud_tick));
	// ---------------------------------------------------------------
	// Shared tasks, all but chk entered and left at a rising edge
	// ---------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clk_sys);
		sfr_wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk_sys);
		sfr_rd <= 1'b0;
		#1 chk(sfr_rdata, exp);
		@(posedge clk_sys);
	endtask
	task automatic ackp(input int i);
		ack[i] <= 1'b1;
		@(posedge clk_sys);
		ack[i] <= 1'b0;
		@(posedge clk_sys);
		chk(flg[i], 1'b0);
	endtask
	task automatic waitf(input int i, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (flg[i] !== 1'b1 && n < lim);
		chk(flg[i], 1'b1);
	endtask
	// Third wait measures a whole period; the first may be cut by a reconfigure
	task automatic gap(input int b, input logic [15:0] exp);
		int n;
		for (int k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(posedge clk_sys);
				n++;
			end while (baud_tick[b] !== 1'b1 && n < 3000);
		end
		chk(16'(n), exp);
	endtask
	task automatic cfg(input logic [1:0] m, input logic [7:0] p);
		uart0_mode <= m;
		uart1_mode <= m;
		wr(A_POWER_CONTROL, p);
	endtask
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_regs();
		for (int a = 0; a < 13; a++) rd(8'(a), 8'h00);
		wr(8'h20, 8'h5A);
		rd(8'h20, 8'h00);
		wr(A_TIMER_MODE_SELECT, 8'h22);
		rd(A_TIMER_MODE_SELECT, 8'h22);
		$display("test regs done");
	endtask
	task automatic t_timer();
		wr(A_T0L, 8'hFF);
		wr(A_T0H, 8'hFF);
		wr(A_TIMER_MODE_SELECT, 8'h01);
		wr(A_TIMER_CONTROL, 8'h10);
		waitf(0, 40);
		repeat (60) @(posedge clk_sys);
		rd(A_T0L, 8'h05);
		ackp(0);
		wr(A_TIMER_CONTROL, 8'h00);
		wr(A_T0L, 8'h77);
		repeat (30) @(posedge clk_sys);
		rd(A_T0L, 8'h77);
		int0_pin <= 1'b0;
		wr(A_TIMER_MODE_SELECT, 8'h09);
		wr(A_TIMER_CONTROL, 8'h10);
		repeat (30) @(posedge clk_sys);
		rd(A_T0L, 8'h77);
		wr(A_TIMER_CONTROL, 8'h00);
		int0_pin <= 1'b1;
		clk_en <= 1'b0;
		wr(A_T0L, 8'h11);
		rd(A_T0L, 8'h77);
		clk_en <= 1'b1;
		rd(A_T0L, 8'h77);
		$display("test timer done");
	endtask
	task automatic t_events();
		wr(A_TIMER_MODE_SELECT, 8'h05);
		wr(A_T0L, 8'h00);
		wr(A_TIMER_CONTROL, 8'h10);
		repeat (3) u_pins.fall(0);
		rd(A_T0L, 8'h03);
		wr(A_TIMER_CONTROL, 8'h04);
		u_pins.fall(4);
		chk(ext_int1_edge_flag, 1'b1);
		ackp(2);
		wr(A_T2L, 8'h34);
		wr(A_T2H, 8'h12);
		wr(A_TIMER2_CONTROL, 8'h0F);
		u_pins.fall(3);
		rd(A_RLDL, 8'h34);
		rd(A_RLDH, 8'h12);
		chk(t2_ext_flag, 1'b1);
		wr(A_T2L, 8'h55);
		wr(A_TIMER2_CONTROL, 8'h0E);
		u_pins.fall(2);
		rd(A_T2L, 8'h56);
		u_pins.fall(3);
		rd(A_T2L, 8'h34);
		$display("test events done");
	endtask
	task automatic t_baud();
		wr(A_TIMER_MODE_SELECT, 8'h20);
		wr(A_T1H, 8'hFD);
		wr(A_T1L, 8'hFD);
		wr(A_TIMER_CONTROL, 8'h40);
		waitf(1, 60);
		rd(A_T1L, 8'hFD);
		ackp(1);
		cfg(2'h1, 8'h00);
		gap(0, 16'd1152);
		cfg(2'h3, 8'h80);
		gap(0, 16'd576);
		cfg(2'h2, 8'h00);
		gap(0, 16'd64);
		cfg(2'h2, 8'h80);
		gap(0, 16'd32);
		cfg(2'h0, 8'h00);
		gap(0, 16'd12);
		wr(A_T2L, 8'hFE);
		wr(A_T2H, 8'hFF);
		wr(A_RLDL, 8'hFE);
		wr(A_RLDH, 8'hFF);
		wr(A_TIMER2_CONTROL, 8'h14);
		cfg(2'h1, 8'h10);
		gap(1, 16'd384);
		gap(3, 16'd384);
		gap(0, 16'd1152);
		chk(t2_overflow_flag, 1'b0);
		$display("test baud done");
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		t_regs();
		t_timer();
		t_events();
		t_baud();
		summarize();
	end
	// Tests need under 12000 cycles; over three times that means a hang
	initial begin
		repeat (40000) @(posedge clk_sys);
		bad_count++;
		summarize();
	end
endmodule

/* File: tcb_pin_model.sv */
/*
 Far side model: count pins 0..2, Timer 2 trigger, interrupt 1 pin.
 Assumes the bench calls fall() at a rising edge of clk_sys.
*/
module tcb_pin_model (
	input wire logic clk_sys,
	output logic [4:0] pins
);
	timeunit 1ns;
	timeprecision 1ps;
	initial pins = 5'h1F;
	// Two machine cycles per level, so no level can slip between samples
	task automatic fall(input int i);
		pins[i] <= 1'b0;
		repeat (24) @(posedge clk_sys);
		pins[i] <= 1'b1;
		repeat (24) @(posedge clk_sys);
	endtask
endmodule

/* File: tcb_pkg.sv */
/*
 Constants, field positions and the state carrier of the timer/counter block.
 Assumes one oscillator clock, so the phase counts below are in oscillator periods.
*/
package tcb_pkg;
	// ---------------------------------------------------------------
	// Machine cycle phases
	// ---------------------------------------------------------------
	localparam int OSC_PER_STATE = 2;
	localparam int STATES_PER_MC = 6;
	localparam int OSC_PER_MC = OSC_PER_STATE * STATES_PER_MC;
	localparam logic [3:0] PH_LAST = 4'(OSC_PER_MC - 1);
	localparam logic [3:0] PH_S3P1 = 4'h4;
	localparam logic [3:0] PH_S5P2 = 4'h9;
	// ---------------------------------------------------------------
	// Register addresses on the special function port
	// ---------------------------------------------------------------
	localparam logic [7:0] A_TIMER_CONTROL = 8'h00;
	localparam logic [7:0] A_TIMER_MODE_SELECT = 8'h01;
	localparam logic [7:0] A_T0L = 8'h02;
	localparam logic [7:0] A_T0H = 8'h03;
	localparam logic [7:0] A_T1L = 8'h04;
	localparam logic [7:0] A_T1H = 8'h05;
	localparam logic [7:0] A_TIMER2_CONTROL = 8'h06;
	localparam logic [7:0] A_T2AUX = 8'h07;
	localparam logic [7:0] A_RLDL = 8'h08;
	localparam logic [7:0] A_RLDH = 8'h09;
	localparam logic [7:0] A_T2L = 8'h0A;
	localparam logic [7:0] A_T2H = 8'h0B;
	localparam logic [7:0] A_POWER_CONTROL = 8'h0C;
	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int TC_TF1 = 7;
	localparam int TC_TR1 = 6;
	localparam int TC_TF0 = 5;
	localparam int TC_TR0 = 4;
	localparam int TC_IE1 = 3;
	localparam int TC_IT1 = 2;
	localparam int TM_GATE1 = 7;
	localparam int TM_CT1 = 6;
	localparam int TM_M1 = 4;
	localparam int TM_GATE0 = 3;
	localparam int TM_CT0 = 2;
	localparam int TM_M0 = 0;
	localparam int T2_TF2 = 7;
	localparam int T2_RCLK = 5;
	localparam int T2_TX_CLOCK_SELECT = 4;
	localparam int T2_T2_EXTERNAL_ENABLE = 3;
	localparam int T2_TR2 = 2;
	localparam int T2_CT2 = 1;
	localparam int T2_CPR = 0;
	localparam int X2_DIR = 0;
	localparam int X2_EXF = 1;
	localparam logic [7:0] X2_MASK = 8'h03;
	localparam int PC_DOUBLE_RATE_BIT = 7;
	localparam int PC_PORT2_RX_CLOCK_SELECT = 5;
	localparam int PC_PORT2_TX_CLOCK_SELECT = 4;
	// ---------------------------------------------------------------
	// Pin indices, modes and baud divisors
	// ---------------------------------------------------------------
	localparam int PIN_C0 = 0;
	localparam int PIN_C1 = 1;
	localparam int PIN_C2 = 2;
	localparam int PIN_TRIG = 3;
	localparam int PIN_INT0 = 4;
	localparam int PIN_INT1 = 5;
	localparam logic [1:0] MODE_13 = 2'h0;
	localparam logic [1:0] MODE_16 = 2'h1;
	localparam logic [1:0] MODE_8R = 2'h2;
	localparam logic [1:0] MODE_SPLIT = 2'h3;
	localparam logic [1:0] SER_M0 = 2'h0;
	localparam logic [1:0] SER_M2 = 2'h2;
	localparam logic [4:0] BAUD_T1_SLOW = 5'h1F;
	localparam logic [4:0] BAUD_T1_FAST = 5'h0F;
	localparam logic [4:0] BAUD_T2 = 5'h0F;
	localparam int BT_U0RX = 0;
	localparam int BT_U0TX = 1;
	localparam int BT_U1RX = 2;
	localparam int BT_U1TX = 3;

	typedef struct packed {
		logic [7:0] timer_control;
		logic [7:0] timer_mode_select;
		logic [7:0] timer2_control;
		logic [7:0] t2aux;
		logic [7:0] power_control;
		logic [15:0] t0;
		logic [15:0] t1;
		logic [15:0] t2;
		logic [15:0] rld;
		logic [3:0] ph;
		logic [5:0] sy1;
		logic [5:0] sy2;
		logic [5:0] samp;
		logic [3:0] pend;
		logic [5:0] odiv;
		logic [3:0][4:0] bdiv;
		logic [3:0] btick;
		logic [7:0] rdata;
	} tcb_state_t;
endpackage

/* File: tcb_timers.sv */
/*
 Three timer/counters, external interrupt 1 flag and serial baud tick generation.
 Assumes the core drives the register port and interrupt acknowledges on clk_sys,
 and that clk_sys is the oscillator.
*/
// Overview of operation
// RULE1: Machine cycle is six states of two oscillator periods, twelve in all.
// RULE2: Timer function increments once per machine cycle, oscillator over twelve.
// RULE3: Counter function samples pin at S5P2, counts a high-then-low pair.
// RULE4: Count after detected fall appears at S3P1 of the following machine cycle.
// RULE5: External source holds each level at least one full machine cycle.
// RULE6: Per-timer select bit picks timer or counter; two-bit field picks mode.
// RULE7: Overflow sets the timer flag; interrupt vectoring clears it.
// RULE8: Software run bit starts and stops the timer; counts only while set.
// RULE9: External interrupt 1 flag set on edge, cleared on service; type bit chooses.
// RULE10: Timer 2 auto-reload with external enable also reloads on trigger fall.
// RULE11: Timer 2 capture counts up; trigger fall copies counter to capture registers.
// RULE12: Timer 2 baud mode raises no overflow flag; trigger becomes extra interrupt.
// RULE13: Timer 2 baud mode rollover reloads whole counter from reload registers.
// RULE14: Clock select bits route each direction of each serial port to Timer 2.
// RULE15: Serial mode 0 ticks at oscillator over twelve.
// RULE16: Serial mode 2 ticks at oscillator over 64, or over 32 with double rate.
// RULE17: Modes 1 and 3 tick at Timer 1 overflow times double factor over 32.
// RULE18: Timer 1 in 8-bit reload gives oscillator/(12*(256-reload)) before division.
// RULE19: Modes 2 reload low byte from high byte on low byte overflow, set flag.
module tcb_timers
	import tcb_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic count_pin_0,
	input wire logic count_pin_1,
	input wire logic count_pin_2,
	input wire logic t2_trigger_input,
	input wire logic ext_int0_pin,
	input wire logic ext_int1_pin,
	input wire logic t0_int_ack,
	input wire logic t1_int_ack,
	input wire logic ext1_int_ack,
	input wire logic [1:0] uart0_mode,
	input wire logic [1:0] uart1_mode,
	output logic t0_overflow_flag,
	output logic t1_overflow_flag,
	output logic ext_int1_edge_flag,
	output logic t2_overflow_flag,
	output logic t2_ext_flag,
	output logic [3:0] baud_tick
);
	// ---------------------------------------------------------------
	// Step function for Timer 0/1 modes
	// ---------------------------------------------------------------
	function automatic logic [16:0] tcb_step(input logic [15:0] c, input logic [1:0] m);
		logic [16:0] r;
		logic [13:0] s;
		// Mode 0 is 13 bits: five low bits, then the high byte; bits 7:5 stay put
		r = {1'b0, c};
		s = 14'({c[15:8], c[4:0]}) + 14'h1;
		case (m)
			MODE_13: r = {s[13], s[12:5], c[7:5], s[4:0]};
			MODE_16: r = 17'(c) + 17'h1;
			MODE_8R: r = (c[7:0] == 8'hFF) ? {1'b1, c[15:8], c[15:8]} : {1'b0, c[15:8], c[7:0] + 8'h1}; // RULE19
			// Mode 3 low byte runs as a plain 8-bit counter
			default: r = {c[7:0] == 8'hFF, c[15:8], c[7:0] + 8'h1};
		endcase
		return r;
	endfunction

	tcb_state_t q, d;
	logic mc_s3, mc_s5, mc_end, osc_wrap, double_rate_bit;
	logic [5:0] fall, pins;
	logic ev0, ev1, ev2, trig, run0, run1;
	logic ovf0, ovf0h, ovf1, ovf2, set_tf1, set_exf, brg, cap, down;
	logic use_t2, src;
	logic [1:0] smode;
	logic [4:0] lim;
	logic [3:0] sel;
	logic [16:0] st;
	logic [8:0] sh;

	assign pins = {ext_int1_pin, ext_int0_pin, t2_trigger_input, count_pin_2, count_pin_1, count_pin_0};

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		d = q;
		ovf0 = 1'b0;
		ovf0h = 1'b0;
		ovf1 = 1'b0;
		ovf2 = 1'b0;
		set_exf = 1'b0;
		st = '0;
		sh = '0;
		use_t2 = 1'b0;
		src = 1'b0;
		smode = SER_M0;
		lim = '0;
		mc_s3 = (q.ph == PH_S3P1);
		mc_s5 = (q.ph == PH_S5P2);
		mc_end = (q.ph == PH_LAST);
		d.ph = mc_end ? 4'h0 : q.ph + 4'h1; // RULE1
		// Only the second flop is read; the first may still be settling
		d.sy1 = pins;
		d.sy2 = q.sy1;
		fall = q.samp & ~q.sy2;
		// Falls are judged only on the S5P2 sample pair
		if (mc_s5) begin
			d.samp = q.sy2; // RULE3
			d.pend = q.pend | fall[3:0]; // RULE3
		end
		// Pending falls are used at S3P1 and then dropped
		if (mc_s3) begin
			d.pend = '0; // RULE4
		end
		// Every count lands at S3P1, so a pin count trails its fall by one cycle
		ev0 = mc_s3 & (q.timer_mode_select[TM_CT0] ? q.pend[PIN_C0] : 1'b1); // RULE2 RULE4 RULE6
		ev1 = mc_s3 & (q.timer_mode_select[TM_CT1] ? q.pend[PIN_C1] : 1'b1); // RULE2 RULE4 RULE6
		ev2 = mc_s3 & (q.timer2_control[T2_CT2] ? q.pend[PIN_C2] : 1'b1); // RULE2 RULE4
		trig = mc_s3 & q.pend[PIN_TRIG] & q.timer2_control[T2_T2_EXTERNAL_ENABLE] & q.timer2_control[T2_TR2];

		// ---------------------------------------------------------------
		// Timer 0 and Timer 1
		// ---------------------------------------------------------------
		// Gate pins act through the second synchroniser flop only
		run0 = q.timer_control[TC_TR0] & (~q.timer_mode_select[TM_GATE0] | q.sy2[PIN_INT0]); // RULE8
		run1 = q.timer_control[TC_TR1] & (~q.timer_mode_select[TM_GATE1] | q.sy2[PIN_INT1]); // RULE8
		if (run0 & ev0) begin
			st = tcb_step(q.t0, q.timer_mode_select[TM_M0 +: 2]); // RULE6
			d.t0 = st[15:0];
			ovf0 = st[16];
		end
		// Split mode: high byte of Timer 0 borrows run bit and flag of Timer 1
		if (q.timer_mode_select[TM_M0 +: 2] == MODE_SPLIT && q.timer_control[TC_TR1] && mc_s3) begin
			sh = {1'b0, q.t0[15:8]} + 9'h1; // RULE6
			d.t0[15:8] = sh[7:0];
			ovf0h = sh[8];
		end
		if (run1 & ev1 & (q.timer_mode_select[TM_M1 +: 2] != MODE_SPLIT)) begin
			st = tcb_step(q.t1, q.timer_mode_select[TM_M1 +: 2]); // RULE6
			d.t1 = st[15:0];
			ovf1 = st[16];
		end
		// Timer 1 keeps its own flag unless Timer 0 runs split
		set_tf1 = (q.timer_mode_select[TM_M0 +: 2] == MODE_SPLIT) ? ovf0h : ovf1;

		// ---------------------------------------------------------------
		// Timer 2
		// ---------------------------------------------------------------
		brg = q.timer2_control[T2_RCLK] | q.timer2_control[T2_TX_CLOCK_SELECT]; // RULE14
		cap = q.timer2_control[T2_CPR] & ~brg;
		// Down counting only in plain auto-reload; the trigger pin sets the direction
		down = ~brg & ~cap & q.t2aux[X2_DIR] & ~q.sy2[PIN_TRIG];
		// Underflow wraps to FFFF only in down mode; up mode reloads or wraps to zero
		if (q.timer2_control[T2_TR2] & ev2) begin
			if (down) begin
				ovf2 = (q.t2 == q.rld);
				d.t2 = ovf2 ? 16'hFFFF : q.t2 - 16'h1;
			end else if (q.t2 == 16'hFFFF) begin
				ovf2 = 1'b1;
				d.t2 = cap ? 16'h0000 : q.rld; // RULE11 RULE13
			end else begin
				d.t2 = q.t2 + 16'h1; // RULE11
			end
		end
		if (trig) begin
			set_exf = 1'b1; // RULE12
			// Capture takes the value from before this cycle's count
			if (cap) begin
				d.rld = q.t2; // RULE11
			end else if (!brg && !q.t2aux[X2_DIR]) begin
				d.t2 = q.rld; // RULE10
			end
		end

		// ---------------------------------------------------------------
		// Baud ticks
		// ---------------------------------------------------------------
		double_rate_bit = q.power_control[PC_DOUBLE_RATE_BIT];
		d.odiv = q.odiv + 6'h01;
		osc_wrap = double_rate_bit ? (q.odiv[4:0] == 5'h1F) : (q.odiv == 6'h3F); // RULE16
		sel = {q.power_control[PC_PORT2_TX_CLOCK_SELECT], q.power_control[PC_PORT2_RX_CLOCK_SELECT], q.timer2_control[T2_TX_CLOCK_SELECT], q.timer2_control[T2_RCLK]}; // RULE14
		// A divisor moves only on its source overflow, so the first tick after a switch may be early
		for (int k = 0; k < 4; k++) begin
			use_t2 = sel[k];
			smode = (k < 2) ? uart0_mode : uart1_mode;
			src = use_t2 ? (ovf2 & brg) : ovf1; // RULE17 RULE18
			lim = use_t2 ? BAUD_T2 : (double_rate_bit ? BAUD_T1_FAST : BAUD_T1_SLOW); // RULE17
			d.btick[k] = 1'b0;
			case (smode)
				SER_M0: d.btick[k] = mc_end; // RULE15
				SER_M2: d.btick[k] = osc_wrap; // RULE16
				default: begin
					if (src) begin
						d.btick[k] = (q.bdiv[k] == lim);
						d.bdiv[k] = (q.bdiv[k] == lim) ? 5'h00 : q.bdiv[k] + 5'h01;
					end
				end
			endcase
		end

		// ---------------------------------------------------------------
		// Register port; a write to a counter wins over its own count
		// ---------------------------------------------------------------
		// Unmapped writes leave every register as it was
		if (sfr_wr) begin
			case (sfr_addr)
				A_TIMER_CONTROL: d.timer_control = sfr_wdata; // RULE8
				A_TIMER_MODE_SELECT: d.timer_mode_select = sfr_wdata;
				A_T0L: d.t0[7:0] = sfr_wdata;
				A_T0H: d.t0[15:8] = sfr_wdata;
				A_T1L: d.t1[7:0] = sfr_wdata;
				A_T1H: d.t1[15:8] = sfr_wdata;
				A_TIMER2_CONTROL: d.timer2_control = sfr_wdata;
				A_T2AUX: d.t2aux = sfr_wdata & X2_MASK;
				A_RLDL: d.rld[7:0] = sfr_wdata;
				A_RLDH: d.rld[15:8] = sfr_wdata;
				A_T2L: d.t2[7:0] = sfr_wdata;
				A_T2H: d.t2[15:8] = sfr_wdata;
				A_POWER_CONTROL: d.power_control = sfr_wdata;
				default: d.rdata = q.rdata;
			endcase
		end

		// ---------------------------------------------------------------
		// Flags
		// ---------------------------------------------------------------
		// Hardware set beats a clear in the same cycle
		if (!(sfr_wr && sfr_addr == A_TIMER_CONTROL)) begin
			d.timer_control[TC_TF0] = q.timer_control[TC_TF0] & ~t0_int_ack; // RULE7
			d.timer_control[TC_TF1] = q.timer_control[TC_TF1] & ~t1_int_ack; // RULE7
			d.timer_control[TC_IE1] = q.timer_control[TC_IE1] & ~ext1_int_ack; // RULE9
		end
		d.timer_control[TC_TF0] = d.timer_control[TC_TF0] | ovf0; // RULE7
		d.timer_control[TC_TF1] = d.timer_control[TC_TF1] | set_tf1; // RULE7
		// Level mode follows the inverted pin, so an acknowledge has no effect there
		if (q.timer_control[TC_IT1]) begin
			d.timer_control[TC_IE1] = d.timer_control[TC_IE1] | (mc_s5 & fall[PIN_INT1]); // RULE9
		end else begin
			d.timer_control[TC_IE1] = ~q.sy2[PIN_INT1]; // RULE9
		end
		// Timer 2 flags have no acknowledge; software clears them by a write
		d.timer2_control[T2_TF2] = d.timer2_control[T2_TF2] | (ovf2 & ~brg); // RULE12
		d.t2aux[X2_EXF] = d.t2aux[X2_EXF] | set_exf; // RULE12


		// ---------------------------------------------------------------
		// Read data
		// ---------------------------------------------------------------
		// A read beside a write in one cycle returns the old value
		if (sfr_rd) begin
			case (sfr_addr)
				A_TIMER_CONTROL: d.rdata = q.timer_control;
				A_TIMER_MODE_SELECT: d.rdata = q.timer_mode_select;
				A_T0L: d.rdata = q.t0[7:0];
				A_T0H: d.rdata = q.t0[15:8];
				A_T1L: d.rdata = q.t1[7:0];
				A_T1H: d.rdata = q.t1[15:8];
				A_TIMER2_CONTROL: d.rdata = q.timer2_control;
				A_T2AUX: d.rdata = q.t2aux;
				A_RLDL: d.rdata = q.rld[7:0];
				A_RLDH: d.rdata = q.rld[15:8];
				A_T2L: d.rdata = q.t2[7:0];
				A_T2H: d.rdata = q.t2[15:8];
				A_POWER_CONTROL: d.rdata = q.power_control;
				default: d.rdata = 8'h00;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// State registers
	// ---------------------------------------------------------------
	// Pin history resets high so no false fall is seen after release
	// Low clk_en holds every flop, phase counter and synchronisers included
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
			q.sy1 <= '1;
			q.sy2 <= '1;
			q.samp <= '1;
		end else if (clk_en) begin
			q <= d;
		end
	end


	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	// Flags are register bits, so they change only on an enabled edge or at reset
	assign sfr_rdata = q.rdata;
	assign t0_overflow_flag = q.timer_control[TC_TF0];
	assign t1_overflow_flag = q.timer_control[TC_TF1];
	assign ext_int1_edge_flag = q.timer_control[TC_IE1];
	assign t2_overflow_flag = q.timer2_control[T2_TF2];
	assign t2_ext_flag = q.t2aux[X2_EXF];
	assign baud_tick = q.btick;
endmodule

/* File: tcb_timers_sva.sv */
/*
 Port checker for tcb_timers, bound at the foot of this file.
 Assumes the phase count starts at S1P1 on the first edge after reset.
*/
module tcb_timers_sva
	import tcb_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic t0_int_ack,
	input wire logic t1_int_ack,
	input wire logic [1:0] uart0_mode,
	input wire logic t0_overflow_flag,
	input wire logic t1_overflow_flag,
	input wire logic [3:0] baud_tick
);
	logic [3:0] ph_q, ph_d;
	logic [7:0] gap_q, gap_d, run_q, run_d;
	// ---------------------------------------------------------------
	// Helper counters
	// ---------------------------------------------------------------
	// run_q restarts on a divisor change, the first gap after it may be short
	always_comb begin
		ph_d = ph_q;
		if (clk_en) ph_d = (ph_q == PH_LAST) ? 4'h0 : ph_q + 4'h1;
		gap_d = baud_tick[1] ? 8'h00 : ((gap_q == 8'hFF) ? gap_q : gap_q + 8'h01);
		run_d = (run_q == 8'hFF) ? run_q : run_q + 8'h01;
		if (uart0_mode != SER_M2 || (sfr_wr && sfr_addr == A_POWER_CONTROL)) run_d = 8'h00;
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ph_q <= 4'h0;
			gap_q <= 8'h00;
			run_q <= 8'h00;
		end else begin
			ph_q <= ph_d;
			gap_q <= gap_d;
			run_q <= run_d;
		end
	end
	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	a_tick_single: assert property (baud_tick[0] && clk_en |=> !baud_tick[0])
		else $error("baud tick wider than one cycle");
	a_mode0_period: assert property (clk_en && uart0_mode == SER_M0 |=> baud_tick[0] == (ph_q == 4'h0))
		else $error("mode 0 tick not every 12 clocks");
	a_mode2_spacing: assert property (baud_tick[1] && uart0_mode == SER_M2 && run_q > 8'h50 |-> gap_q >= 8'd31)
		else $error("mode 2 ticks too close");
	a_t0_flag_phase: assert property ($rose(t0_overflow_flag) && !$past(sfr_wr) |-> ph_q == PH_S3P1 + 4'h1)
		else $error("timer 0 flag set off the count phase");
	a_t1_flag_phase: assert property ($rose(t1_overflow_flag) && !$past(sfr_wr) |-> ph_q == PH_S3P1 + 4'h1)
		else $error("timer 1 flag set off the count phase");
	a_t0_ack_clear: assert property (t0_int_ack && clk_en && !sfr_wr && ph_q != PH_S3P1 |=> !t0_overflow_flag)
		else $error("timer 0 flag kept after vectoring");
	a_t1_ack_clear: assert property (t1_int_ack && clk_en && !sfr_wr && ph_q != PH_S3P1 |=> !t1_overflow_flag)
		else $error("timer 1 flag kept after vectoring");
	a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data changed without a read");
	a_unmapped_zero: assert property (sfr_rd && clk_en && sfr_addr > A_POWER_CONTROL |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	c_port1_tick: cover property (baud_tick[3]);
	c_t1_flag: cover property ($rose(t1_overflow_flag));
	c_unmapped: cover property (sfr_rd && sfr_addr > A_POWER_CONTROL);
endmodule
bind tcb_timers tcb_timers_sva u_sva (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
	.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
	.t0_int_ack(t0_int_ack), .t1_int_ack(t1_int_ack), .uart0_mode(uart0_mode),
	.t0_overflow_flag(t0_overflow_flag), .t1_overflow_flag(t1_overflow_flag), .baud_tick(baud_tick));
